// ---- rtl/dcpwm_unit.sv ----
// Two-channel 16-bit PWM unit with frame byte writes and readback.
`timescale 1ns/1ps
`include "dcpwm_defs.svh"

module dcpwm_unit
  import dcpwm_pkg::*;
#(
  parameter int SERVO_FRAME_TICKS = `DCPWM_US_TO_TICKS(`DCPWM_SERVO_FRAME_US),
  parameter int SERVO_MIN_TICKS   = `DCPWM_US_TO_TICKS(`DCPWM_SERVO_MIN_US),
  parameter int SERVO_MAX_WORD    = `DCPWM_SERVO_MAX_WORD
)
(
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic       byteWrEn,
  input  wire logic [6:0] byteIdx,
  input  wire logic [7:0] byteWrData,
  input  wire logic [3:0] sensorPinsActive,
  output logic      [7:0] byteRdData_ff,
  output logic            wave_channel_a_ff,
  output logic            wave_channel_b_ff,
  output logic      [1:0] channelRunning_ff
);

  // ******************************************************************
  // Helper functions
  // ******************************************************************

  // Returns the prescaler divide; zero means the timebase is stopped.
  // The three top codes share the slowest divide, so every code has a
  // meaning and no setting leaves the timebase undefined.
  function automatic logic [10:0] psDivide(input logic [2:0] ps);
    case (ps)
      3'h0:    psDivide = 11'h000;
      3'h1:    psDivide = 11'h001;
      3'h2:    psDivide = 11'h008;
      3'h3:    psDivide = 11'h040;
      3'h4:    psDivide = 11'h100;
      default: psDivide = 11'h400;
    endcase
  endfunction

  // Computes period and high time, in timebase ticks, for one channel.
  function automatic dcpwm_len_t calcLen(input dcpwm_ctrl_t c,
                                         input logic [15:0] word,
                                         input logic [15:0] period);
    dcpwm_len_t  l;
    logic [15:0] clampW;
    logic [31:0] minW;
    l = '0;
    clampW = '0;
    minW = '0;
    case (c.mode)
      // Halving the word maps the full range onto one extra millisecond,
      // so the pulse grows linearly up to the clamp.
      DCPWM_SERVO:
      begin
        clampW = (word > 16'(SERVO_MAX_WORD)) ?
                 16'(SERVO_MAX_WORD) : word;
        l.per = 18'(SERVO_FRAME_TICKS);
        l.hi  = 18'(SERVO_MIN_TICKS) + 18'(clampW[15:1]);
      end
      // The minimum word is rounded up, so a clamped setting lands at or
      // below the frequency ceiling, never above it.
      DCPWM_FREQ:
      begin
        minW = (32'(`DCPWM_MIN_PS_WORD) + 32'(psDivide(c.ps)) - 32'h1)
               / ((psDivide(c.ps) == 11'h0) ? 32'h1 : 32'(psDivide(c.ps)));
        l.per = (32'(word) < minW) ? 18'(minW) : 18'(word);
        l.hi  = {1'b0, l.per[17:1]};
      end
      // Duty and universal share one period word; a word above it
      // saturates the high time so the output stays high all period.
      default:
      begin
        l.per = 18'(period);
        l.hi  = (word > period) ? 18'(period) : 18'(word);
      end
    endcase
    calcLen = l;
  endfunction

  // ******************************************************************
  // Process and control bytes
  // ******************************************************************

  logic [7:0]  bytes_ff [`DCPWM_NUM_BYTES];
  logic [6:0]  relIdx;
  logic        idxHit;

  assign relIdx = byteIdx - `DCPWM_IDX_CTRL0;
  assign idxHit = (byteIdx >= `DCPWM_IDX_CTRL0) &&
                  (byteIdx <= `DCPWM_IDX_B_HIGH);

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      for (int k = 0; k < `DCPWM_NUM_BYTES; k++)
      begin
        bytes_ff[k] <= `DCPWM_BYTE_RESET;
      end
    end
    else if (ce && byteWrEn && idxHit)
    begin
      bytes_ff[relIdx[2:0]] <= byteWrData;
    end
  end

  // ******************************************************************
  // Readback
  // ******************************************************************

  // Unmapped indices read zero so a stray read never looks like a setting.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      byteRdData_ff <= 8'h00;
    end
    else if (ce)
    begin
      byteRdData_ff <= idxHit ? bytes_ff[relIdx[2:0]] : 8'h00;
    end
  end

  dcpwm_ctrl_t liveCtrl;
  logic [15:0] periodWord;
  logic [15:0] chanWord [2];

  assign liveCtrl   = dcpwm_ctrl_t'(bytes_ff[0]);
  assign periodWord = {bytes_ff[2], bytes_ff[1]};
  assign chanWord[0] = {bytes_ff[4], bytes_ff[3]};
  assign chanWord[1] = {bytes_ff[6], bytes_ff[5]};

  // ******************************************************************
  // Configuration latch and shared timebase
  // ******************************************************************

  dcpwm_ctrl_t cfg_ff;
  dcpwm_ctrl_t nxt_cfg;
  logic [1:0]  boundary;
  logic [1:0]  enLive;
  logic        tick_ff;
  logic [23:0] acc_ff;
  logic [23:0] accSum;
  logic [23:0] accLimit;
  logic [10:0] div;

  assign enLive = {liveCtrl.enB, liveCtrl.enA};

  // Mode and prescaler move only at a channel A period end, or at once while A is off,
  // so the shared timebase never cuts an A pulse short.
  assign nxt_cfg = (boundary[0] || !enLive[0]) ? liveCtrl : cfg_ff;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      cfg_ff <= dcpwm_ctrl_t'(`DCPWM_BYTE_RESET);
    end
    else if (ce)
    begin
      cfg_ff <= nxt_cfg;
    end
  end

  // A phase accumulator turns the 10 MHz clock into the halved core rate; the
  // servo frame ignores the prescaler.
  // Each tick therefore jitters by one clock, but period lengths average
  // out exactly, which matters more to a stepper drive than one edge.
  // The accumulator limit stays below its width for the slowest divide.
  assign div      = (cfg_ff.mode == DCPWM_SERVO) ? 11'h001 :
                    psDivide(cfg_ff.ps);
  assign accSum   = acc_ff + 24'(`DCPWM_TICK_KHZ);
  assign accLimit = 24'(`DCPWM_REF_CLK_KHZ) * 24'(div);

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      acc_ff  <= 24'h000000;
      tick_ff <= 1'b0;
    end
    else if (ce)
    begin
      if (div == 11'h000)
      begin
        acc_ff  <= 24'h000000;
        tick_ff <= 1'b0;
      end
      else if (accSum >= accLimit)
      begin
        acc_ff  <= accSum - accLimit;
        tick_ff <= 1'b1;
      end
      else
      begin
        acc_ff  <= accSum;
        tick_ff <= 1'b0;
      end
    end
  end

  // ******************************************************************
  // Channel counters
  // ******************************************************************

  logic [17:0] cnt_ff  [2];
  dcpwm_len_t  len_ff  [2];
  logic [1:0]  highNow;

  for (genvar g = 0; g < 2; g++)
  begin : gChan
    assign boundary[g] = tick_ff && enLive[g] &&
                         ((cnt_ff[g] + 18'h1) >= len_ff[g].per);
    assign highNow[g]  = enLive[g] && (cnt_ff[g] < len_ff[g].hi);

    always_ff @(posedge ref_clk)
    begin
      if (rst)
      begin
        cnt_ff[g] <= 18'h00000;
        len_ff[g] <= '0;
      end
      else if (ce)
      begin
        if (!enLive[g])
        begin
          // Held at period start while off, loaded fresh for the restart.
          cnt_ff[g] <= 18'h00000;
          len_ff[g] <= calcLen(nxt_cfg, chanWord[g], periodWord);
        end
        else if (boundary[g])
        begin
          cnt_ff[g] <= 18'h00000;
          len_ff[g] <= calcLen(nxt_cfg, chanWord[g], periodWord);
        end
        else if (tick_ff)
        begin
          cnt_ff[g] <= cnt_ff[g] + 18'h1;
        end
      end
    end
  end

  // ******************************************************************
  // Outputs
  // ******************************************************************

  logic halfB_ff;
  logic blocked;

  // Channel B in universal mode toggles on every A period end, doubling the period.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      halfB_ff <= 1'b0;
    end
    else if (ce)
    begin
      if (!enLive[0] || !enLive[1])
      begin
        halfB_ff <= 1'b0;
      end
      else if (boundary[0])
      begin
        halfB_ff <= ~halfB_ff;
      end
    end
  end

  // Lockout watches the live mode byte, not the latched one, so the
  // outputs drop at once instead of waiting for a period end.
  assign blocked = (|sensorPinsActive) && (liveCtrl.mode == DCPWM_FREQ);

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      wave_channel_a_ff <= 1'b0;
      wave_channel_b_ff <= 1'b0;
      channelRunning_ff <= 2'b00;
    end
    else if (ce)
    begin
      wave_channel_a_ff <= !blocked && highNow[0];
      if (cfg_ff.mode == DCPWM_UNIVERSAL)
      begin
        wave_channel_b_ff <= !blocked && enLive[1] && halfB_ff;
      end
      else
      begin
        wave_channel_b_ff <= !blocked && highNow[1];
      end
      channelRunning_ff <= blocked ? 2'b00 : enLive;
    end
  end

endmodule

// ---- rtl/dcpwm_defs.svh ----
// Offsets, field positions, reset values and timing counts of the PWM unit.
`ifndef DCPWM_DEFS_SVH
`define DCPWM_DEFS_SVH

// Byte indices within the exchange frame.
`define DCPWM_IDX_CTRL0      7'd19
`define DCPWM_IDX_PER_LOW    7'd20
`define DCPWM_IDX_PER_HIGH   7'd21
`define DCPWM_IDX_A_LOW      7'd22
`define DCPWM_IDX_A_HIGH     7'd23
`define DCPWM_IDX_B_LOW      7'd24
`define DCPWM_IDX_B_HIGH     7'd25
`define DCPWM_NUM_BYTES      7

`define DCPWM_BYTE_RESET     8'h00

// First control byte fields.
`define DCPWM_MODE_LSB       0
`define DCPWM_EN_B_BIT       3
`define DCPWM_EN_A_BIT       4
`define DCPWM_PS_LSB         5

// Timing: core timebase after the fixed divide by two.
`define DCPWM_REF_CLK_KHZ    10000
`define DCPWM_CORE_KHZ       16000
`define DCPWM_TICK_KHZ       (`DCPWM_CORE_KHZ / 2)
`define DCPWM_FMAX_HZ        20000
`define DCPWM_MIN_PS_WORD    ((`DCPWM_TICK_KHZ * 1000 + `DCPWM_FMAX_HZ - 1) \
                              / `DCPWM_FMAX_HZ)
`define DCPWM_SERVO_FRAME_US 20000
`define DCPWM_SERVO_MIN_US   1000
`define DCPWM_SERVO_MAX_WORD 16000
`define DCPWM_US_TO_TICKS(u) ((u) * `DCPWM_TICK_KHZ / 1000)

`endif

// ---- rtl/dcpwm_pkg.sv ----
// Types shared by the dual channel PWM unit.
package dcpwm_pkg;

  typedef enum logic [1:0]
  {
    DCPWM_SERVO,
    DCPWM_DUTY,
    DCPWM_UNIVERSAL,
    DCPWM_FREQ
  } dcpwm_mode_t;

  typedef struct packed
  {
    logic [2:0]  ps;
    logic        enA;
    logic        enB;
    logic        spare;
    dcpwm_mode_t mode;
  } dcpwm_ctrl_t;

  typedef struct packed
  {
    logic [17:0] per;
    logic [17:0] hi;
  } dcpwm_len_t;

endpackage

// ---- dv/dcpwm_host.sv ----
// Host model that writes and reads frame bytes of the PWM unit.
`timescale 1ns/1ps
module dcpwm_host
(
  input  logic       ref_clk,
  input  logic [7:0] rdData,
  output logic       wrEn,
  output logic [6:0] idx,
  output logic [7:0] wrData
);
  // Bytes arrive deframed, so serial timing is left out on purpose.
  initial
  begin
    wrEn = 1'b0;
    idx = 7'h00;
    wrData = 8'h00;
  end
  task automatic wr(input logic [6:0] i, input logic [7:0] d);
    @(posedge ref_clk);
    wrEn <= 1'b1;
    idx <= i;
    wrData <= d;
    @(posedge ref_clk);
    wrEn <= 1'b0;
    wrData <= ~d;
  endtask
  task automatic rd(input logic [6:0] i, output logic [7:0] d);
    @(posedge ref_clk);
    idx <= i;
    repeat (2) @(posedge ref_clk);
    #1 d = rdData;
  endtask
endmodule

// ---- dv/dcpwm_assertions.sv ----
// Port checker of the dual channel PWM unit.
`timescale 1ns/1ps
module dcpwm_chk
  import dcpwm_pkg::*;
#(
  parameter int SERVO_FRAME_TICKS = 200
)
(
  input logic       ref_clk,
  input logic       rst,
  input logic       ce,
  input logic       byteWrEn,
  input logic [6:0] byteIdx,
  input logic [7:0] byteWrData,
  input logic [3:0] sensorPinsActive,
  input logic [7:0] byteRdData_ff,
  input logic       wave_channel_a_ff,
  input logic       wave_channel_b_ff,
  input logic [1:0] channelRunning_ff
);
  localparam int FrameCyc = SERVO_FRAME_TICKS * 10 / 8;
  logic [7:0]  sh_ff [19:25];
  logic [10:0] quiet_ff;
  logic [10:0] gap_ff;
  logic        inMap;
  logic        calm;
  logic [1:0]  mode;
  logic [15:0] wordA;
  logic [15:0] perW;
  assign inMap = byteIdx >= 7'd19 && byteIdx <= 7'd25;
  // Words latch at period ends, so checks wait until writes are long past.
  assign calm  = quiet_ff == 11'h7ff;
  assign mode  = sh_ff[19][1:0];
  assign wordA = {sh_ff[23], sh_ff[22]};
  assign perW  = {sh_ff[21], sh_ff[20]};
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      for (int i = 19; i <= 25; i++)
        sh_ff[i] <= 8'h00;
    else if (ce && byteWrEn && inMap)
      sh_ff[byteIdx] <= byteWrData;
  end
  always_ff @(posedge ref_clk)
  begin
    if (rst || (byteWrEn && inMap))
      quiet_ff <= 11'h000;
    else if (!calm)
      quiet_ff <= quiet_ff + 11'h001;
  end
  always_ff @(posedge ref_clk)
  begin
    if (rst || $rose(wave_channel_a_ff))
      gap_ff <= 11'h001;
    else if (gap_ff != 11'h7ff)
      gap_ff <= gap_ff + 11'h001;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_reset_clear: assert property (disable iff (1'b0)
    rst |=> byteRdData_ff == 8'h00 && channelRunning_ff == 2'b00)
    else $error("outputs not cleared by reset");
  a_read_back: assert property (ce && byteWrEn && inMap ##1
    ce && !byteWrEn && $stable(byteIdx) |=>
    byteRdData_ff == $past(byteWrData, 2))
    else $error("byte readback differs from write");
  a_unmapped_zero: assert property (ce && !inMap |=> byteRdData_ff == 8'h00)
    else $error("unmapped byte not zero");
  a_en_a: assert property (!sh_ff[19][4] [*3] |-> !channelRunning_ff[0])
    else $error("channel A runs while off");
  a_en_b: assert property (!sh_ff[19][3] [*3] |-> !channelRunning_ff[1])
    else $error("channel B runs while off");
  a_sensor_off: assert property ((calm && mode == 2'b11
    && sensorPinsActive != 4'h0) [*3] |-> channelRunning_ff == 2'b00
    && !wave_channel_a_ff && !wave_channel_b_ff)
    else $error("outputs live under sensor lockout");
  a_duty_low: assert property (calm && mode == 2'b01
    && wordA == 16'h0000 && !wave_channel_a_ff |=> !wave_channel_a_ff)
    else $error("zero duty word pulses");
  a_duty_high: assert property (calm && mode == 2'b01
    && wordA > perW && wave_channel_a_ff |=> wave_channel_a_ff)
    else $error("overfull duty word drops");
  a_servo_frame: assert property (calm && mode == 2'b00
    && $rose(wave_channel_a_ff) |-> gap_ff >= FrameCyc - 1
    && gap_ff <= FrameCyc + 1)
    else $error("servo frame length wrong");
  c_servo: cover property (calm && mode == 2'b00 && $rose(wave_channel_a_ff));
  c_lock: cover property (calm && mode == 2'b11 && sensorPinsActive != 4'h0);
  c_high: cover property (calm && mode == 2'b01 && wordA > perW);
endmodule
bind dcpwm_unit dcpwm_chk #(.SERVO_FRAME_TICKS(SERVO_FRAME_TICKS)) u_chk (
  .ref_clk(ref_clk), .rst(rst), .ce(ce), .byteWrEn(byteWrEn),
  .byteIdx(byteIdx), .byteWrData(byteWrData),
  .sensorPinsActive(sensorPinsActive), .byteRdData_ff(byteRdData_ff),
  .wave_channel_a_ff(wave_channel_a_ff),
  .wave_channel_b_ff(wave_channel_b_ff),
  .channelRunning_ff(channelRunning_ff));

// ---- dv/testbench.sv ----
// Self-checking bench of the dual channel PWM unit.
`timescale 1ns/1ps
module testbench;
  import dcpwm_pkg::*;
  logic        ref_clk = 1'b0;
  logic        ce = 1'b1;
  logic        lvlA;
  logic        rst = 1'b1;
  logic [3:0]  sensor = 4'h0;
  logic        wrEn;
  logic [6:0]  idx;
  logic [7:0]  wrData;
  logic [7:0]  rdData;
  logic        waveA;
  logic        waveB;
  logic [1:0]  running;
  logic [15:0] seed = 16'h4f21;
  logic [15:0] w;
  logic [7:0]  b;
  int          bad_count = 0;
  int          checks_done = 0;
  int          hi;
  int          per;
  int          sw [4] = '{0, 10, 20, 100};
  always #50 ref_clk = ~ref_clk;
  dcpwm_unit #(.SERVO_FRAME_TICKS(200), .SERVO_MIN_TICKS(10),
    .SERVO_MAX_WORD(20)) u_dut (.ref_clk(ref_clk), .rst(rst), .ce(ce),
    .byteWrEn(wrEn), .byteIdx(idx), .byteWrData(wrData),
    .sensorPinsActive(sensor), .byteRdData_ff(rdData),
    .wave_channel_a_ff(waveA), .wave_channel_b_ff(waveB),
    .channelRunning_ff(running));
  dcpwm_host u_host (.ref_clk(ref_clk), .rdData(rdData), .wrEn(wrEn),
    .idx(idx), .wrData(wrData));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Timebase is 8 MHz over prescaler, sampled at 10 MHz: 1.25 cycles a tick.
  function automatic int cyc(input int ticks, input int ps);
    return ticks * ps * 10 / 8;
  endfunction
  task automatic check(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task automatic near(input string what, input int exp, input int got);
    check(what, exp, (got >= exp - 2 && got <= exp + 2) ? exp : got);
  endtask
  task automatic run(input logic s, input logic lvl, input int cap,
    output int n);
    n = 0;
    while ((s ? waveB : waveA) === lvl && n < cap)
    begin
      @(posedge ref_clk);
      #1 n++;
    end
  endtask
  task automatic meas(input logic s);
    int lo;
    run(s, 1'b1, 30000, hi);
    run(s, 1'b0, 30000, hi);
    run(s, 1'b1, 30000, hi);
    run(s, 1'b0, 30000, lo);
    per = hi + lo;
  endtask
  task automatic cfg(input logic [7:0] c, input logic [15:0] p,
    input logic [15:0] a, input logic [15:0] bw);
    logic [47:0] v;
    v = {bw, a, p};
    for (int i = 0; i < 6; i++)
      u_host.wr(7'(20 + i), v[i * 8 +: 8]);
    u_host.wr(7'd19, c);
    repeat (2200) @(posedge ref_clk);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    #(100000 * 100);
    bad_count++;
    finish_test();
  end
  initial
  begin
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    for (int i = 19; i < 27; i++)
    begin
      u_host.rd(7'(i), b);
      check("reset byte", 8'h00, b);
    end
    for (int i = 20; i < 26; i++)
    begin
      seed = lfsr(seed);
      u_host.wr(7'(i), seed[7:0]);
      u_host.rd(7'(i), b);
      check("readback", seed[7:0], b);
    end
    $display("byte tests done");
    seed = lfsr(seed);
    w = 16'(10 + seed % 80);
    cfg(8'h39, 16'd100, w, 16'd25);
    meas(1'b0);
    near("duty A high", cyc(w, 1), hi);
    near("duty A period", 125, per);
    meas(1'b1);
    near("duty B high", cyc(25, 1), hi);
    near("duty B period", 125, per);
    @(posedge ref_clk);
    ce <= 1'b0;
    #1 lvlA = waveA;
    u_host.wr(7'd22, 8'hff);
    repeat (300) @(posedge ref_clk);
    #1 check("frozen A", lvlA, waveA);
    @(posedge ref_clk);
    ce <= 1'b1;
    u_host.rd(7'd22, b);
    check("frozen write", w[7:0], b);
    cfg(8'h39, 16'd100, 16'd0, 16'd200);
    run(1'b0, 1'b0, 400, hi);
    check("A held low", 400, hi);
    run(1'b1, 1'b1, 400, hi);
    check("B held high", 400, hi);
    cfg(8'h3a, 16'd100, 16'd50, 16'd200);
    meas(1'b1);
    near("univ B period", 250, per);
    near("univ B high", 125, hi);
    $display("duty tests done");
    cfg(8'h3b, 16'd100, 16'd800, 16'd10);
    meas(1'b0);
    near("freq A high", 500, hi);
    near("freq A period", 1000, per);
    meas(1'b1);
    near("freq B clamp", 500, per);
    cfg(8'h5b, 16'd100, 16'd100, 16'd10);
    meas(1'b0);
    near("ps8 A period", cyc(100, 8), per);
    meas(1'b1);
    near("ps8 B clamp", cyc(50, 8), per);
    @(posedge ref_clk);
    sensor <= 4'h2;
    repeat (10) @(posedge ref_clk);
    check("locked run", 2'b00, running);
    run(1'b0, 1'b0, 400, hi);
    check("locked A", 400, hi);
    @(posedge ref_clk);
    sensor <= 4'h0;
    $display("frequency tests done");
    for (int i = 0; i < 4; i++)
    begin
      cfg(8'h38, 16'd100, 16'(sw[i]), 16'd20);
      meas(1'b0);
      near("servo high", cyc(10 + (sw[i] > 20 ? 20 : sw[i]) / 2, 1), hi);
      near("servo frame", 250, per);
    end
    $display("servo tests done");
    u_host.wr(7'd19, 8'h31);
    repeat (3) @(posedge ref_clk);
    #1 check("only A", 2'b01, running);
    u_host.wr(7'd19, 8'h29);
    repeat (3) @(posedge ref_clk);
    #1 check("only B", 2'b10, running);
    u_host.wr(7'd19, 8'h7b);
    u_host.rd(7'd19, b);
    check("code 7b", 8'h7b, b);
    check("7b both", 2'b11, running);
    u_host.wr(7'd19, 8'hf9);
    repeat (3) @(posedge ref_clk);
    #1 check("f9 both", 2'b11, running);
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    u_host.rd(7'd22, b);
    check("second reset", 8'h00, b);
    check("reset run", 2'b00, running);
    $display("enable tests done");
    finish_test();
  end
endmodule
